/* File: core/nvr_pkg.sv */
// constants, types and operation list for the nonvolatile ram host controller
// Operation
// - new row needs select fall or row change
// - select rise precharges; hold high minimum time
// - random accesses spaced by random cycle time
// - select-ended write: data valid at select rise
// - meet access time, hold data, pulse each write
// - further strobe pulses write columns of open row
// - sleep low ignores pins; wait exit delay after
// - finish accesses before entering sleep
// - six reads at fixed addresses enter protect update
// - write byte, complement, then write and read
// - select low at start: access 00000h first
package nvr_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int COL_W = 2;
  localparam int SECTOR_LSB = 14;
  localparam int PROT_W = 8;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  localparam int CNT_W = 4;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RANDOM_CYCLE_TIME_NS = 110;
  localparam int PAGE_ACCESS_TIME_NS = 25;
  localparam int PRECHARGE_TIME_NS = 50;
  localparam int SLEEP_EXIT_DELAY_NS = 450;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  localparam logic [CNT_W-1:0] ACCESS_CYC = CNT_W'(ceil_cyc(RANDOM_CYCLE_TIME_NS));
  localparam logic [CNT_W-1:0] PAGE_CYC = CNT_W'(ceil_cyc(PAGE_ACCESS_TIME_NS));
  localparam logic [CNT_W-1:0] PRECH_CYC = CNT_W'(ceil_cyc(PRECHARGE_TIME_NS));
  localparam logic [CNT_W-1:0] SLEEP_CYC = CNT_W'(ceil_cyc(SLEEP_EXIT_DELAY_NS));
  localparam logic [CNT_W-1:0] SYNC_CYC = CNT_W'(SYNC_STAGES);

  localparam logic [REG_AW-1:0] REG_ADDR = 4'h0;
  localparam logic [REG_AW-1:0] REG_WDATA = 4'h1;
  localparam logic [REG_AW-1:0] REG_CMD = 4'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
  localparam logic [REG_AW-1:0] REG_RDATA = 4'h4;
  localparam logic [REG_AW-1:0] REG_PROT = 4'h5;

  localparam int CMD_READ = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_PROT = 2;
  localparam int CMD_SLEEP = 3;
  localparam int CMD_WAKE = 4;
  localparam int CMD_CLOSE = 5;
  localparam int CMD_KEEP = 6;
  localparam int CMD_LOWER = 7;
  localparam int CMD_UPPER = 8;

  localparam int ST_BUSY = 0;
  localparam int ST_ROWOPEN = 1;
  localparam int ST_ASLEEP = 2;
  localparam int ST_DONE = 3;
  localparam int ST_REFUSED = 4;
  localparam int SHADOW_LSB = 8;

  localparam int SEQ_LEN = 10;
  localparam int SEQ_IW = 4;
  localparam logic [SEQ_IW-1:0] SEQ_LAST = 4'h9;
  localparam logic [SEQ_IW-1:0] SEQ_WR_FIRST = 4'h6;
  localparam logic [SEQ_IW-1:0] SEQ_WR_INV = 4'h7;
  localparam logic [SEQ_IW-1:0] SEQ_WR_LAST = 4'h8;
  localparam logic [ADDR_W-1:0] SEQ_ADDR [SEQ_LEN] = '{
    17'h1_2555, 17'h1_DAAA, 17'h0_1333, 17'h0_ECCC, 17'h0_00FF,
    17'h1_FF00, 17'h1_DAAA, 17'h0_ECCC, 17'h0_FF00, 17'h0_0000};

  typedef enum logic [1:0] {
    DSEL_NONE = 2'b00,
    DSEL_BYTE = 2'b01,
    DSEL_INV = 2'b10
  } nvr_dsel_e;

  typedef struct packed {
    logic is_write;
    logic [ADDR_W-1:0] addr;
    nvr_dsel_e dsel;
  } nvr_step_s;

  typedef struct packed {
    logic keep_open;
    logic upper_en;
    logic lower_en;
  } nvr_opts_s;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_SETUP = 4'b0001,
    S_ACTIVE = 4'b0010,
    S_SETTLE = 4'b0011,
    S_OPEN = 4'b0100,
    S_WSET = 4'b0101,
    S_WACT = 4'b0110,
    S_WEND = 4'b0111,
    S_END = 4'b1000,
    S_PRECHG = 4'b1001,
    S_FETCH = 4'b1010,
    S_ISSUE = 4'b1011,
    S_SLEEP = 4'b1100,
    S_WAKE = 4'b1101
  } nvr_state_e;
endpackage : nvr_pkg

/* File: core/nvr_seq_rom.sv */
`timescale 1ns/1ps
// registered table of the protect update bus steps
module nvr_seq_rom
  import nvr_pkg::*;
(
  input wire logic clk,
  input wire logic [SEQ_IW-1:0] idx,
  output nvr_step_s entry_q
);
  nvr_step_s entry_d;

  always_comb begin
    entry_d = '0;
    if (idx <= SEQ_LAST) begin
      entry_d.addr = SEQ_ADDR[idx];
      entry_d.is_write = (idx >= SEQ_WR_FIRST) && (idx <= SEQ_WR_LAST);
      if (idx == SEQ_WR_FIRST) begin
        entry_d.dsel = DSEL_BYTE;
      end else if (idx == SEQ_WR_INV) begin
        entry_d.dsel = DSEL_INV;
      end
    end
  end

  always_ff @(posedge clk) begin
    entry_q <= entry_d;
  end
endmodule : nvr_seq_rom

/* File: core/nvr_ctrl.sv */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// host controller driving the asynchronous nonvolatile ram pins
module nvr_ctrl
  import nvr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  output logic sleep_request_n
);
  localparam int WE_MIN = 3;
  localparam int WE_MAX = 4;

  function automatic logic [ADDR_W-COL_W-1:0] row_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:COL_W];
  endfunction : row_of

  nvr_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0] addr_reg_q, pin_addr_q;
  logic [DATA_W-1:0] wdata_reg_q, rdata_q, dq_o_q, dq_s1_q, dq_s2_q;
  logic [PROT_W-1:0] prot_q, shadow_q;
  nvr_opts_s opts_q, launch_opts;
  logic cmd_write_q, page_hit_q, seq_q, done_q, refused_q;
  logic [SEQ_IW-1:0] step_q;
  logic dq_oe_q, ce_n_q, we_n_q, oe_n_q, ub_n_q, lb_n_q, sleep_n_q;
  logic [REG_DW-1:0] reg_rdata_q;
  nvr_step_s step_ent;
  logic cmd_wr, any_req, at_idle, at_open, cnt_zero;
  logic go_rd, go_wr, go_prot, go_sleep, go_wake, go_close, refuse, op_done;
  logic launch, launch_wr;
  logic [ADDR_W-1:0] launch_addr;
  logic [DATA_W-1:0] launch_data;

  nvr_seq_rom u_rom (
    .clk(clk),
    .idx(step_q),
    .entry_q(step_ent)
  );

  assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
  assign any_req = |reg_wdata[CMD_CLOSE:CMD_READ];
  assign at_idle = (state_q == S_IDLE);
  assign at_open = (state_q == S_OPEN);
  assign cnt_zero = (cnt_q == '0);
  assign go_rd = cmd_wr && reg_wdata[CMD_READ] && (at_idle || at_open);
  assign go_wr = cmd_wr && reg_wdata[CMD_WRITE] && !reg_wdata[CMD_READ] && (at_idle || at_open);
  // protect update only from a closed row, so the select is high at its start
  assign go_prot = cmd_wr && reg_wdata[CMD_PROT] && at_idle;
  // sleep only with no access in flight and the row closed
  assign go_sleep = cmd_wr && reg_wdata[CMD_SLEEP] && at_idle;
  assign go_wake = cmd_wr && reg_wdata[CMD_WAKE] && (state_q == S_SLEEP);
  assign go_close = cmd_wr && reg_wdata[CMD_CLOSE] && at_open;
  assign refuse = cmd_wr && any_req && !(go_rd || go_wr || go_prot || go_sleep || go_wake
    || go_close);

  always_comb begin
    launch = go_rd || go_wr || (state_q == S_ISSUE);
    launch_wr = go_wr;
    launch_addr = addr_reg_q;
    launch_data = wdata_reg_q;
    launch_opts.keep_open = reg_wdata[CMD_KEEP];
    launch_opts.upper_en = reg_wdata[CMD_UPPER];
    launch_opts.lower_en = reg_wdata[CMD_LOWER];
    if (state_q == S_ISSUE) begin
      launch_wr = step_ent.is_write;
      launch_addr = step_ent.addr;
      launch_opts = '{keep_open: 1'b0, upper_en: 1'b1, lower_en: 1'b1};
      case (step_ent.dsel)
        DSEL_BYTE: launch_data = {{(DATA_W-PROT_W){1'b0}}, prot_q};
        DSEL_INV: launch_data = {{(DATA_W-PROT_W){1'b0}}, ~prot_q};
        default: launch_data = '0;
      endcase
    end
  end

  always_comb begin
    op_done = go_sleep || (state_q == S_WAKE && cnt_zero);
    if (state_q == S_PRECHG && cnt_zero && !(seq_q && step_q != SEQ_LAST)) begin
      op_done = 1'b1;
    end
    if ((state_q == S_SETTLE && cnt_zero || state_q == S_WEND) && opts_q.keep_open) begin
      op_done = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        S_IDLE, S_OPEN: begin
          if (launch && launch_wr && at_open) begin
            state_q <= S_WSET;
          end else if (launch) begin
            state_q <= S_SETUP;
          end else if (go_close) begin
            state_q <= S_END;
          end else if (go_prot) begin
            state_q <= S_FETCH;
          end else if (go_sleep) begin
            state_q <= S_SLEEP;
          end
        end
        S_FETCH: state_q <= S_ISSUE;
        S_ISSUE: state_q <= S_SETUP;
        S_SETUP: begin
          state_q <= S_ACTIVE;
          // same row in an open page needs only the column access time
          cnt_q <= page_hit_q ? PAGE_CYC - 1'b1 : ACCESS_CYC - 1'b1;
        end
        S_ACTIVE: begin
          if (cnt_zero) begin
            state_q <= cmd_write_q ? S_END : S_SETTLE;
            cnt_q <= SYNC_CYC - 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_SETTLE: begin
          if (cnt_zero) begin
            state_q <= opts_q.keep_open ? S_OPEN : S_END;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_WSET: begin
          state_q <= S_WACT;
          cnt_q <= ACCESS_CYC - 1'b1;
        end
        S_WACT: begin
          if (cnt_zero) begin
            state_q <= S_WEND;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_WEND: state_q <= opts_q.keep_open ? S_OPEN : S_END;
        S_END: begin
          state_q <= S_PRECHG;
          cnt_q <= PRECH_CYC - 1'b1;
        end
        S_PRECHG: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (seq_q && step_q != SEQ_LAST) begin
            state_q <= S_FETCH;
          end else begin
            state_q <= S_IDLE;
          end
        end
        S_SLEEP: begin
          if (go_wake) begin
            state_q <= S_WAKE;
            cnt_q <= SLEEP_CYC - 1'b1;
          end
        end
        S_WAKE: begin
          if (cnt_zero) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // pin drivers; every pin is a flop so the bus never glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_addr_q <= '0;
      dq_o_q <= '0;
      dq_oe_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      ub_n_q <= 1'b1;
      lb_n_q <= 1'b1;
      sleep_n_q <= 1'b1;
    end else begin
      if (launch) begin
        pin_addr_q <= launch_addr;
        ub_n_q <= !launch_opts.upper_en;
        lb_n_q <= !launch_opts.lower_en;
        oe_n_q <= 1'b1;
        dq_o_q <= launch_data;
        if (launch_wr && !at_open) begin
          // strobe low and data valid before the select falls
          we_n_q <= 1'b0;
          dq_oe_q <= 1'b1;
        end
      end
      case (state_q)
        S_SETUP: begin
          ce_n_q <= 1'b0;
          oe_n_q <= cmd_write_q;
        end
        S_WSET: begin
          we_n_q <= 1'b0;
          dq_oe_q <= 1'b1;
        end
        // strobe held low for the whole access count, raised as the count ends
        S_WACT: we_n_q <= cnt_zero;
        S_WEND: dq_oe_q <= 1'b0;
        S_END: begin
          ce_n_q <= 1'b1;
          oe_n_q <= 1'b1;
        end
        S_PRECHG: begin
          we_n_q <= 1'b1;
          dq_oe_q <= 1'b0;
        end
        S_SLEEP: sleep_n_q <= go_wake;
        default: begin
        end
      endcase
      if (go_sleep) begin
        sleep_n_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_write_q <= 1'b0;
      page_hit_q <= 1'b0;
      opts_q <= '0;
    end else if (launch) begin
      cmd_write_q <= launch_wr;
      page_hit_q <= at_open && (row_of(launch_addr) == row_of(pin_addr_q));
      opts_q <= launch_opts;
    end
  end

  // pin input, two stages before capture
  always_ff @(posedge clk) begin
    dq_s1_q <= mem_dq_i;
    dq_s2_q <= dq_s1_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (state_q == S_SETTLE && cnt_zero) begin
      rdata_q <= dq_s2_q;
    end
  end

  // shadow is only the host's view; the device keeps the real mask
  always_ff @(posedge clk) begin
    if (reset) begin
      seq_q <= 1'b0;
      step_q <= '0;
      shadow_q <= '0;
    end else if (go_prot) begin
      seq_q <= 1'b1;
      step_q <= '0;
    end else if (state_q == S_PRECHG && cnt_zero && seq_q) begin
      if (step_q == SEQ_LAST) begin
        seq_q <= 1'b0;
        shadow_q <= prot_q;
      end else begin
        step_q <= step_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg_q <= '0;
      wdata_reg_q <= '0;
      prot_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == REG_ADDR) begin
        addr_reg_q <= reg_wdata[ADDR_W-1:0];
      end
      if (reg_addr == REG_WDATA) begin
        wdata_reg_q <= reg_wdata[DATA_W-1:0];
      end
      if (reg_addr == REG_PROT && !seq_q) begin
        prot_q <= reg_wdata[PROT_W-1:0];
      end
    end
  end

  // sticky flags: a new event beats the clear from a command write
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= op_done || (done_q && !cmd_wr);
      refused_q <= refuse || (refused_q && !(cmd_wr && !refuse));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_ADDR: reg_rdata_q <= REG_DW'(addr_reg_q);
        REG_WDATA: reg_rdata_q <= REG_DW'(wdata_reg_q);
        REG_RDATA: reg_rdata_q <= REG_DW'(rdata_q);
        REG_PROT: reg_rdata_q <= REG_DW'({shadow_q, prot_q});
        REG_STATUS: begin
          reg_rdata_q <= '0;
          reg_rdata_q[ST_BUSY] <= !(at_idle || at_open || state_q == S_SLEEP);
          reg_rdata_q[ST_ROWOPEN] <= at_open;
          reg_rdata_q[ST_ASLEEP] <= (state_q == S_SLEEP);
          reg_rdata_q[ST_DONE] <= done_q;
          reg_rdata_q[ST_REFUSED] <= refused_q;
        end
        default: reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign mem_addr = pin_addr_q;
  assign mem_dq_o = dq_o_q;
  assign mem_dq_oe = dq_oe_q;
  assign mem_ce_n = ce_n_q;
  assign mem_we_n = we_n_q;
  assign mem_oe_n = oe_n_q;
  assign upper_byte_select_n = ub_n_q;
  assign lower_byte_select_n = lb_n_q;
  assign sleep_request_n = sleep_n_q;

  a_read_we_high: assert property (@(posedge clk) disable iff (reset)
    $fell(ce_n_q) && !cmd_write_q |-> we_n_q && !dq_oe_q)
    else $error("read started with write strobe low");
  a_cewr_we_low: assert property (@(posedge clk) disable iff (reset)
    $fell(ce_n_q) && cmd_write_q |-> !we_n_q && dq_oe_q && oe_n_q)
    else $error("select write started without strobe and data");
  a_cewr_data_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(ce_n_q) && cmd_write_q && !page_hit_q |-> dq_oe_q && $stable(dq_o_q))
    else $error("write data not held at select rise");
  a_precharge_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(ce_n_q) |-> ce_n_q [*3])
    else $error("select high shorter than precharge");
  a_access_len: assert property (@(posedge clk) disable iff (reset)
    $fell(ce_n_q) |-> !ce_n_q [*3])
    else $error("select low shorter than access time");
  a_bus_no_fight: assert property (@(posedge clk) disable iff (reset)
    !oe_n_q |-> !dq_oe_q && we_n_q)
    else $error("host drives while device may drive");
  a_page_we_pulse: assert property (@(posedge clk) disable iff (reset)
    $fell(we_n_q) && !ce_n_q |-> ##[WE_MIN:WE_MAX] $rose(we_n_q))
    else $error("page write strobe pulse wrong length");
  a_sleep_quiet: assert property (@(posedge clk) disable iff (reset)
    !sleep_n_q |-> ce_n_q && we_n_q && !dq_oe_q)
    else $error("pins active during sleep");
  a_wake_delay: assert property (@(posedge clk) disable iff (reset)
    $rose(sleep_n_q) |-> ce_n_q [*8])
    else $error("access before sleep exit delay");
  a_prot_lanes: assert property (@(posedge clk) disable iff (reset)
    seq_q && dq_oe_q |-> dq_o_q[DATA_W-1:PROT_W] == '0)
    else $error("protect byte not on low lanes");
  a_prot_confirm: assert property (@(posedge clk) disable iff (reset)
    seq_q && step_q == SEQ_WR_INV && $fell(ce_n_q) |-> dq_o_q[PROT_W-1:0] == ~prot_q)
    else $error("confirm write is not the complement");

  c_ce_read: cover property (@(posedge clk) disable iff (reset)
    state_q == S_SETTLE && cnt_zero && !opts_q.keep_open);
  c_page_write: cover property (@(posedge clk) disable iff (reset)
    state_q == S_WEND && page_hit_q);
  c_prot_done: cover property (@(posedge clk) disable iff (reset)
    seq_q && step_q == SEQ_LAST && state_q == S_PRECHG);
  c_sleep_wake: cover property (@(posedge clk) disable iff (reset)
    state_q == S_WAKE && cnt_zero);
endmodule : nvr_ctrl

/* File: sim/nvr_dev_model.sv */
// behavioural model of the nonvolatile ram on the far side of the controller
`timescale 1ns/1ps
module nvr_dev_model
  import nvr_pkg::*;
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] dq,
  input wire logic host_oe,
  input wire logic mem_ce_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic sleep_request_n,
  output logic [DATA_W-1:0] dev_dq,
  output logic [1:0] dev_drv,
  output logic [PROT_W-1:0] prot_q,
  output int err_cnt
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] sq [10] = '{17'h1_2555, 17'h1_DAAA, 17'h0_1333, 17'h0_ECCC, 17'h0_00FF,
    17'h1_FF00, 17'h1_DAAA, 17'h0_ECCC, 17'h0_FF00, 17'h0_0000};
  logic [PROT_W-1:0] pend;
  logic [ADDR_W-1:COL_W] row;
  logic wr_act = 0;
  logic rdy = 0;
  logic hit;
  int s = 0;
  realtime t_acc = 0, t_col = 0, t_pre = -100, t_wake = -1000, lat = 60;
  initial begin
    prot_q = '0;
    err_cnt = 0;
  end
  // the select, address and strobe events are gated by the sleep pin, all but the precharge time stamp at select rise, so sleeping ignores them
  always @(negedge mem_ce_n) if (sleep_request_n) begin
    if ($realtime - t_pre < 50 || $realtime - t_wake < 450) err_cnt++;
    t_acc = $realtime;
    lat = 60;
    rdy = 0;
    row = mem_addr[ADDR_W-1:COL_W];
    wr_act = !mem_we_n;
    hit = mem_addr == sq[s] && (!mem_we_n == (s >= 6 && s <= 8));
    if (hit && s == 9) prot_q = pend;
    if (hit && s < 9) s++;
    else s = (mem_addr == sq[0] && mem_we_n) ? 1 : 0;
  end
  always @(mem_addr) if (!mem_ce_n && sleep_request_n) begin
    if (mem_addr[ADDR_W-1:COL_W] != row) begin
      t_acc = $realtime;
      lat = 110;
      row = mem_addr[ADDR_W-1:COL_W];
    end
    t_col = $realtime;
    rdy = 0;
  end
  always @(negedge mem_we_n) if (!mem_ce_n && sleep_request_n) wr_act = 1;
  always @(posedge mem_we_n or posedge mem_ce_n) begin
    if (mem_ce_n) t_pre = $realtime;
    if (wr_act && sleep_request_n) begin
      wr_act = 0;
      if (s == 7) pend = dq[7:0];
      else if (s == 8 && dq[7:0] != ~pend) s = 0;
      else if (s < 8 && !prot_q[mem_addr[ADDR_W-1:SECTOR_LSB]]) begin
        if (!upper_byte_select_n) mem[mem_addr][15:8] = dq[15:8];
        if (!lower_byte_select_n) mem[mem_addr][7:0] = dq[7:0];
      end
    end
  end
  always @(negedge sleep_request_n) if (!mem_ce_n || wr_act) err_cnt++;
  always @(posedge sleep_request_n) t_wake = $realtime;
  // ready is only re-evaluated off the sampling edge of the host
  always @(negedge clk) begin
    rdy <= !mem_ce_n && $realtime - t_acc >= lat && $realtime - t_col >= 25;
    if (host_oe && dev_drv != 2'b00) err_cnt++;
  end
  always @* begin
    dev_dq = mem[mem_addr];
    dev_drv = {2{rdy && sleep_request_n && !mem_ce_n && mem_we_n && !mem_oe_n}}
      & ~{upper_byte_select_n, lower_byte_select_n};
  end
endmodule : nvr_dev_model

/* File: sim/tb_top.sv */
// self-checking bench for the nonvolatile ram host controller
`timescale 1ns/1ps
module tb_top
  import nvr_pkg::*;
;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} nvr_exp_s;
  localparam int LANES = (1 << CMD_LOWER) | (1 << CMD_UPPER);
  localparam int WR = (1 << CMD_WRITE) | LANES;
  localparam int RD = (1 << CMD_READ) | LANES;
  localparam int KEEP = 1 << CMD_KEEP;
  nvr_exp_s exp_q [$];
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, chk = 0, rd_pend = 0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0, reg_rdata;
  logic [ADDR_W-1:0] mem_addr, a_s [8];
  logic [DATA_W-1:0] dq_o, dq_i, dq_last = '0, dev_dq, nd, d_s [8];
  logic dq_oe, ce_n, we_n, oe_n, upper_n, lower_n, sleep_n;
  logic [1:0] drv;
  logic [PROT_W-1:0] prot, m;
  int err_cnt, bad_count = 0, comparisons = 0, seed = 8, i, k;
  always #25 clk = ~clk;
  // released lanes show the inverse of the last level, never a held value
  always @(posedge clk) dq_last <= dq_i;
  for (genvar b = 0; b < 2; b++) begin : g_lane
    assign dq_i[8*b+:8] = dq_oe ? dq_o[8*b+:8] : drv[b] ? dev_dq[8*b+:8] : ~dq_last[8*b+:8];
  end
  nvr_ctrl dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_dq_i(dq_i), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_ce_n(ce_n), .mem_we_n(we_n),
    .mem_oe_n(oe_n), .upper_byte_select_n(upper_n), .lower_byte_select_n(lower_n),
    .sleep_request_n(sleep_n));
  nvr_dev_model dev_u (.clk(clk), .mem_addr(mem_addr), .dq(dq_i), .host_oe(dq_oe),
    .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n), .upper_byte_select_n(upper_n),
    .lower_byte_select_n(lower_n), .sleep_request_n(sleep_n), .dev_dq(dev_dq),
    .dev_drv(drv), .prot_q(prot), .err_cnt(err_cnt));
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  always @(posedge clk) begin
    if (rd_pend) begin
      nvr_exp_s x;
      x = exp_q.pop_front();
      check(x.nm, x.e & x.m, reg_rdata & x.m);
    end
    rd_pend <= reg_rd && chk;
  end
  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e,
      input logic [REG_DW-1:0] mk, input string nm, input logic c);
    @(posedge clk);
    if (c) exp_q.push_back('{nm, e, mk});
    reg_rd <= 1;
    reg_addr <= a;
    chk <= c;
    @(posedge clk);
    reg_rd <= 0;
  endtask : rd
  task automatic cmd(input int c);
    wr(REG_CMD, 32'(c));
    for (int n = 0; n < 100; n++) begin
      rd(REG_STATUS, 0, 0, "", 0);
      #1;
      if (reg_rdata[ST_DONE] === 1'b1) return;
    end
    bad_count++;
    wrap_up();
  endtask : cmd
  task automatic op(input int c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(d));
    cmd(c);
  endtask : op
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    for (i = 0; i < 16; i++) rd(4'(i), 0, '1, "reset value", 1);
    wr(4'hC, $random(seed));
    rd(4'hC, 0, '1, "unmapped", 1);
    for (i = 0; i < 8; i++) begin
      a_s[i] = {i[2:0], 14'($random(seed))};
      d_s[i] = 16'($random(seed));
      op(WR, a_s[i], d_s[i]);
      op(RD, a_s[i], 0);
      rd(REG_RDATA, 32'(d_s[i]), 32'h0000_FFFF, "word", 1);
    end
    nd = 16'($random(seed));
    op(WR & ~(1 << CMD_UPPER), a_s[0], nd);
    d_s[0] = {d_s[0][15:8], nd[7:0]};
    op(RD & ~(1 << CMD_LOWER), a_s[0], 0);
    rd(REG_RDATA, 32'(d_s[0]), 32'h0000_FF00, "upper lane", 1);
    op(RD | KEEP, a_s[1], 0);
    rd(REG_STATUS, 32'(1 << ST_ROWOPEN), 32'(1 << ST_ROWOPEN), "row open", 1);
    for (k = 1; k < 4; k++) begin
      nd = 16'($random(seed));
      op(WR | KEEP, a_s[1] ^ 17'(k), nd);
      op(RD | KEEP, a_s[1] ^ 17'(k), 0);
      rd(REG_RDATA, 32'(nd), 32'h0000_FFFF, "page word", 1);
    end
    // protect must wait for a closed row, so select is high entering it
    wr(REG_CMD, 32'(1 << CMD_PROT));
    rd(REG_STATUS, 32'(1 << ST_REFUSED), 32'(1 << ST_REFUSED), "refused", 1);
    cmd(1 << CMD_CLOSE);
    op(RD, a_s[1], 0);
    rd(REG_RDATA, 32'(d_s[1]), 32'h0000_FFFF, "page base", 1);
    rd(REG_STATUS, 0, 32'h0000_0012, "closed", 1);
    for (k = 0; k < 2; k++) begin
      m = k ? 8'h00 : (8'($random(seed)) | 8'h01) & 8'h7F;
      wr(REG_PROT, 32'(m));
      cmd(1 << CMD_PROT);
      check("device mask", 32'(m), 32'(prot));
      rd(REG_PROT, 32'({m, m}), 32'h0000_FFFF, "shadow", 1);
      for (i = 0; i < 8; i++) begin
        nd = 16'($random(seed));
        if (!m[i]) d_s[i] = nd;
        op(WR, a_s[i], nd);
        op(RD, a_s[i], 0);
        rd(REG_RDATA, 32'(d_s[i]), 32'h0000_FFFF, "sector", 1);
      end
    end
    cmd(1 << CMD_SLEEP);
    check("sleep pin", 0, 32'(sleep_n));
    rd(REG_STATUS, 32'(1 << ST_ASLEEP), 32'(1 << ST_ASLEEP), "asleep", 1);
    cmd(1 << CMD_WAKE);
    op(RD, a_s[3], 0);
    rd(REG_RDATA, 32'(d_s[3]), 32'h0000_FFFF, "after wake", 1);
    repeat (3) @(posedge clk);
    check("device protocol", 0, 32'(err_cnt));
    wrap_up();
  end
endmodule : tb_top
